//--- design/rftc_pkg.sv
// constants, field layouts and types of the resonance filter tuning control
package rftc_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned TUNE_MAX_S   = 10;
  localparam int unsigned TUNE_MAX_CYC = TUNE_MAX_S * CLK_HZ;

  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CODE   = 4'h4;
  localparam logic [3:0] OFS_NOTCH1 = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // ctrl field positions
  localparam int POS_MODE   = 0;
  localparam int POS_ACC    = 3;
  localparam int POS_SSEL   = 4;
  localparam int POS_S2SEL  = 8;
  localparam int POS_N3EN   = 12;
  localparam int POS_N4EN   = 13;
  // notch1 and status field positions
  localparam int POS_N1FREQ = 0;
  localparam int POS_N1SHP  = 16;
  localparam int POS_ECODE  = 8;
  localparam int POS_SHZ    = 16;

  localparam logic [1:0] MODE_DIS  = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_MAN  = 2'h2;
  localparam logic       ACC_STD   = 1'h0;
  localparam logic       ACC_HI    = 1'h1;
  localparam logic [1:0] SSEL_AUTO = 2'h0;
  localparam logic [1:0] SSEL_MAN  = 2'h1;
  localparam logic [1:0] SSEL_DIS  = 2'h2;
  localparam logic       S2_DIS    = 1'h0;
  localparam logic       S2_AUTO   = 1'h1;

  localparam logic [1:0]  RST_MODE   = 2'h0;
  localparam logic [1:0]  RST_SSEL   = 2'h0;
  localparam logic        RST_S2SEL  = 1'h1;
  localparam logic [7:0]  RST_CODE   = 8'h00;
  localparam logic [12:0] RST_N1FREQ = 13'h0000;
  localparam logic [3:0]  RST_N1SHP  = 4'h0;

  localparam logic [12:0] BAND_LO_HZ = 13'h0064;
  localparam logic [12:0] BAND_HI_HZ = 13'h08ca;
  localparam logic [1:0]  EXC_STD    = 2'h1;
  localparam logic [1:0]  EXC_HI     = 2'h3;

  // frequency = FREQ_NUMER / divisor; low group divisor 4*code, high group code-0x20
  localparam logic [15:0] FREQ_NUMER = 16'h8ca0;
  localparam logic [7:0]  CODE_G1_LO = 8'h02;
  localparam logic [7:0]  CODE_G1_HI = 8'h1f;
  localparam logic [7:0]  CODE_G2_LO = 8'h28;
  localparam logic [7:0]  CODE_MAX   = 8'h9f;
  localparam logic [7:0]  CODE_G2_OF = 8'h20;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_DETECT = 1'b1
  } rftc_st_t;
endpackage

//--- design/rftc_freq_div.sv
// shift-subtract divider producing the shaft filter frequency from its divisor
`timescale 1ns/1ps
module rftc_freq_div import rftc_pkg::*; (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        start_in,
  input  wire logic [7:0]  divisor_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [12:0]      quotient_out
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [4:0]  cnt;
    logic [7:0]  d;
    logic [8:0]  r;
    logic [15:0] q;
    logic [12:0] res;
  } rftc_div_t;

  rftc_div_t s_reg;
  rftc_div_t s_next;

  always_comb begin
    logic [8:0] rem;
    rem = {s_reg.r[7:0], s_reg.q[15]};
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start_in && !s_reg.busy) begin
      s_next.busy = 1'b1;
      s_next.cnt  = 5'h00;
      s_next.d    = divisor_in;
      s_next.r    = 9'h000;
      s_next.q    = FREQ_NUMER;
    end else if (s_reg.busy) begin
      if (rem >= {1'b0, s_reg.d}) begin
        s_next.r = rem - {1'b0, s_reg.d};
        s_next.q = {s_reg.q[14:0], 1'b1};
      end else begin
        s_next.r = rem;
        s_next.q = {s_reg.q[14:0], 1'b0};
      end
      s_next.cnt = s_reg.cnt + 5'h01;
      if (s_reg.cnt == 5'h0f) begin
        // smallest legal divisor is 8, so the quotient fits 13 bits
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.res  = s_next.q[12:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_out     = s_reg.busy;
  assign done_out     = s_reg.done;
  assign quotient_out = s_reg.res;
endmodule // rftc_freq_div

//--- design/rftc_top.sv
// adaptive notch tuning sequencer and shaft resonance filter control with register slave
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module rftc_top import rftc_pkg::*; #(
  parameter int unsigned TUNE_LIMIT_CYC = TUNE_MAX_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        quick_tuning_busy_in,
  input  wire logic        resonance_valid_in,
  input  wire logic [12:0] resonance_freq_in,
  input  wire logic [3:0]  resonance_depth_in,
  input  wire logic [3:0]  motor_type_in,
  input  wire logic [7:0]  inertia_ratio_in,
  output logic             tuning_busy_out,
  output logic             excite_en_out,
  output logic [1:0]       excite_amp_out,
  output logic             high_accuracy_out,
  output logic [12:0]      notch1_frequency_setting_out,
  output logic [3:0]       notch1_shape_setting_out,
  output logic             shaft_filter1_en_out,
  output logic [12:0]      shaft_filter_freq_out,
  output logic             shaft_filter2_en_out
);
  typedef struct packed {
    logic [1:0]  mode;
    logic        acc;
    logic [1:0]  ssel;
    logic        s2sel;
    logic        n3en;
    logic        n4en;
    logic [7:0]  man_code;
    logic [12:0] n1freq;
    logic [3:0]  n1shp;
    rftc_st_t    st;
    logic [31:0] tcnt;
    logic        detected;
    logic        timed_out;
    logic        excite;
    logic [1:0]  amp;
    logic [7:0]  eff_code;
    logic [7:0]  loaded_code;
    logic        div_start;
    logic [12:0] shz;
    logic        s1on;
    logic        s2on;
    logic        waitreq;
    logic [31:0] rdata;
  } rftc_state_t;

  rftc_state_t s_reg;
  rftc_state_t s_next;
  logic        div_busy;
  logic        div_done;
  logic [12:0] div_q;

  // divisor for a frequency code; zero marks a disabled code
  function automatic logic [7:0] code_div(input logic [7:0] code);
    if (code >= CODE_G1_LO && code <= CODE_G1_HI) begin
      code_div = {code[5:0], 2'b00};
    end else if (code >= CODE_G2_LO && code <= CODE_MAX) begin
      code_div = code - CODE_G2_OF;
    end else begin
      code_div = 8'h00;
    end
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(input rftc_state_t x);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_MODE +: 2] = x.mode;
    w[POS_ACC]       = x.acc;
    w[POS_SSEL +: 2] = x.ssel;
    w[POS_S2SEL]     = x.s2sel;
    w[POS_N3EN]      = x.n3en;
    w[POS_N4EN]      = x.n4en;
    return w;
  endfunction

  function automatic logic [31:0] notch_word(input rftc_state_t x);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_N1FREQ +: 13] = x.n1freq;
    w[POS_N1SHP +: 4]   = x.n1shp;
    return w;
  endfunction

  logic in_band;
  logic tune_found;
  logic [7:0] auto_code;
  logic [7:0] eff_code;
  assign in_band = resonance_freq_in >= BAND_LO_HZ && resonance_freq_in <= BAND_HI_HZ;
  assign tune_found = s_reg.st == ST_DETECT && s_reg.mode == MODE_AUTO && !quick_tuning_busy_in
                      && resonance_valid_in && in_band;

  always_comb begin
    logic [8:0]  sum;
    sum = 9'(CODE_G2_LO) + {3'b000, motor_type_in, 2'b00} + {3'b000, inertia_ratio_in[7:2]};
    auto_code = (sum > 9'(CODE_MAX)) ? CODE_MAX : sum[7:0];
    // filter 1 forced off under notch 4
    unique case (s_reg.ssel)
      SSEL_AUTO: eff_code = s_reg.n4en ? 8'h00 : auto_code;
      SSEL_MAN:  eff_code = s_reg.n4en ? 8'h00 : s_reg.man_code;
      default:   eff_code = 8'h00;
    endcase
  end

  always_comb begin
    logic        req;
    logic [31:0] w;
    req = avs_read_in || avs_write_in;
    w   = 32'h0000_0000;
    s_next = s_reg;
    s_next.div_start = 1'b0;

    // one wait cycle on every access, answer on the second edge
    s_next.waitreq = !(req && s_reg.waitreq);
    if (req && s_reg.waitreq) begin
      unique case (avs_address_in)
        OFS_CTRL:   s_next.rdata = ctrl_word(s_reg);
        OFS_CODE:   s_next.rdata = {24'h00_0000, s_reg.man_code};
        OFS_NOTCH1: s_next.rdata = notch_word(s_reg);
        OFS_STATUS: begin
          w = 32'h0000_0000;
          w[0] = s_reg.st == ST_DETECT;
          w[1] = s_reg.detected;
          w[2] = s_reg.timed_out;
          w[3] = s_reg.s1on;
          w[4] = s_reg.s2on;
          w[POS_ECODE +: 8] = s_reg.eff_code;
          w[POS_SHZ +: 13]  = s_reg.shz;
          s_next.rdata = w;
        end
        default:    s_next.rdata = 32'h0000_0000;
      endcase
    end

    if (avs_write_in && !s_reg.waitreq) begin
      if (avs_address_in == OFS_CTRL) begin
        w = be_merge(ctrl_word(s_reg), avs_writedata_in, avs_byteenable_in);
        if (w[POS_MODE +: 2] != 2'h3) begin
          s_next.mode = w[POS_MODE +: 2];
        end
        s_next.acc  = w[POS_ACC];
        s_next.n3en = w[POS_N3EN];
        s_next.n4en = w[POS_N4EN];
        if (!s_reg.n4en && w[POS_SSEL +: 2] != 2'h3) begin
          s_next.ssel = w[POS_SSEL +: 2];
        end
        if (!s_reg.n3en) begin
          s_next.s2sel = w[POS_S2SEL];
        end
      end else if (avs_address_in == OFS_CODE) begin
        if (!s_reg.n4en && avs_byteenable_in[0]) begin
          s_next.man_code = avs_writedata_in[7:0];
        end
      end else if (avs_address_in == OFS_NOTCH1) begin
        w = be_merge(notch_word(s_reg), avs_writedata_in, avs_byteenable_in);
        s_next.n1freq = w[POS_N1FREQ +: 13];
        s_next.n1shp  = w[POS_N1SHP +: 4];
      end
    end

    // tuning sequencer; its writes come last so they beat a software write
    unique case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.mode == MODE_AUTO && !quick_tuning_busy_in) begin
          s_next.st        = ST_DETECT;
          s_next.tcnt      = 32'h0000_0000;
          s_next.detected  = 1'b0;
          s_next.timed_out = 1'b0;
        end
      end
      ST_DETECT: begin
        if (quick_tuning_busy_in || s_reg.mode != MODE_AUTO) begin
          s_next.st = ST_IDLE;
        end else if (tune_found) begin
          s_next.n1freq   = resonance_freq_in;
          s_next.n1shp    = resonance_depth_in;
          s_next.detected = 1'b1;
          s_next.mode     = MODE_MAN;
          s_next.st       = ST_IDLE;
        end else if (s_reg.tcnt >= TUNE_LIMIT_CYC - 1) begin
          // bounded detection, no resonance leaves the filter off
          s_next.n1freq    = RST_N1FREQ;
          s_next.n1shp     = RST_N1SHP;
          s_next.timed_out = 1'b1;
          s_next.mode      = MODE_MAN;
          s_next.st        = ST_IDLE;
        end else begin
          // counter stops at the limit so it never runs past it while idle
          s_next.tcnt = s_reg.tcnt + 32'h0000_0001;
        end
      end
    endcase
    s_next.excite = s_next.st == ST_DETECT;
    s_next.amp = (s_next.acc == ACC_HI) ? EXC_HI : EXC_STD;

    // shaft filter 1 frequency: recompute whenever the effective code moves
    s_next.eff_code = eff_code;
    if (eff_code != s_reg.loaded_code) begin
      s_next.s1on = 1'b0;
      s_next.shz  = 13'h0000;
      if (!div_busy) begin
        s_next.loaded_code = eff_code;
        s_next.div_start   = code_div(eff_code) != 8'h00;
      end
    end else if (div_done) begin
      s_next.shz  = div_q;
      s_next.s1on = 1'b1;
    end
    // filter 2 forced off under notch 3
    // from the committed state, so a write clearing notch 3 cannot enable filter 2 at once
    s_next.s2on = s_reg.s2sel == S2_AUTO && !s_reg.n3en;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
      s_reg.mode    <= RST_MODE;
      s_reg.ssel    <= RST_SSEL;
      s_reg.s2sel   <= RST_S2SEL;
      s_reg.man_code <= RST_CODE;
      s_reg.n1freq  <= RST_N1FREQ;
      s_reg.n1shp   <= RST_N1SHP;
      s_reg.st      <= ST_IDLE;
      s_reg.amp     <= EXC_STD;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  rftc_freq_div u_div (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .start_in     (s_reg.div_start),
    .divisor_in   (code_div(s_reg.loaded_code)),
    .busy_out     (div_busy),
    .done_out     (div_done),
    .quotient_out (div_q)
  );

  assign avs_readdata_out             = s_reg.rdata;
  assign avs_waitrequest_out          = s_reg.waitreq;
  assign tuning_busy_out              = s_reg.excite;
  assign excite_en_out                = s_reg.excite;
  assign excite_amp_out               = s_reg.amp;
  assign high_accuracy_out            = s_reg.acc;
  assign notch1_frequency_setting_out = s_reg.n1freq;
  assign notch1_shape_setting_out     = s_reg.n1shp;
  assign shaft_filter1_en_out         = s_reg.s1on;
  assign shaft_filter_freq_out        = s_reg.shz;
  assign shaft_filter2_en_out         = s_reg.s2on;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence seq_found;
    tune_found;
  endsequence
  sequence seq_handed;
    s_reg.mode == MODE_MAN && s_reg.st == ST_IDLE;
  endsequence

  a_mode_leave_auto: assert property (
    s_reg.st == ST_DETECT && s_reg.mode != MODE_AUTO |=> s_reg.st == ST_IDLE)
    else $error("detection kept running outside automatic mode");
  a_notch_hw_write: assert property (
    seq_found |=> notch1_frequency_setting_out == $past(resonance_freq_in)
                  && notch1_shape_setting_out == $past(resonance_depth_in))
    else $error("notch 1 not written with detected resonance");
  a_detect_bounded: assert property (
    s_reg.tcnt < TUNE_LIMIT_CYC)
    else $error("detection ran past its limit");
  a_mode_handover: assert property (
    seq_found |=> seq_handed)
    else $error("mode did not turn to manual after tuning");
  a_band_reject: assert property (
    s_reg.st == ST_DETECT && s_reg.mode == MODE_AUTO && !quick_tuning_busy_in
    && resonance_valid_in && !in_band && s_reg.tcnt < TUNE_LIMIT_CYC - 1
    |=> s_reg.st == ST_DETECT && $stable(notch1_frequency_setting_out))
    else $error("out of band resonance was accepted");
  a_quick_refuse: assert property (
    quick_tuning_busy_in |=> !tuning_busy_out && !excite_en_out)
    else $error("tuning ran during quick tuning");
  a_excite_start: assert property (
    $rose(excite_en_out) |-> $past(s_reg.mode) == MODE_AUTO)
    else $error("excitation started outside automatic mode");
  a_excite_amp: assert property (
    excite_en_out |-> excite_amp_out == (high_accuracy_out ? EXC_HI : EXC_STD))
    else $error("excitation amplitude does not follow accuracy");
  a_manual_code: assert property (
    s_reg.ssel == SSEL_MAN && !s_reg.n4en |=> s_reg.eff_code == $past(s_reg.man_code))
    else $error("manual shaft code not applied");
  a_shaft1_block: assert property (
    s_reg.n4en |=> !shaft_filter1_en_out)
    else $error("shaft filter 1 active with notch 4 enabled");
  a_shaft2_block: assert property (
    s_reg.n3en |=> !shaft_filter2_en_out)
    else $error("shaft filter 2 active with notch 3 enabled");
  a_code_valid: assert property (
    shaft_filter1_en_out |-> code_div(s_reg.loaded_code) != 8'h00 && shaft_filter_freq_out != 0)
    else $error("shaft filter on with a disabled code");
endmodule // rftc_top

//--- tb/resonance_filter_tuning_ctrl_test.sv
// self-checking bench for the resonance filter tuning control block
`timescale 1ns/1ps
module resonance_filter_tuning_ctrl_test import rftc_pkg::*;;
  // short detection limit keeps the timeout scenario within a few hundred cycles
  localparam int unsigned LIM   = 200;
  localparam int          LIMIT = 20000;
  logic        clk_sys_in           = 1'b0;
  logic        reset_n_in           = 1'b0;
  logic [3:0]  avs_address_in       = 4'h0;
  logic        avs_read_in          = 1'b0;
  logic        avs_write_in         = 1'b0;
  logic [31:0] avs_writedata_in     = 32'h0;
  logic [3:0]  avs_byteenable_in    = 4'hf;
  logic        quick_tuning_busy_in = 1'b0;
  logic        resonance_valid_in   = 1'b0;
  logic [12:0] resonance_freq_in    = 13'h0;
  logic [3:0]  resonance_depth_in   = 4'h0;
  logic [3:0]  motor_type_in        = 4'h0;
  logic [7:0]  inertia_ratio_in     = 8'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        tuning_busy_out;
  logic        excite_en_out;
  logic [1:0]  excite_amp_out;
  logic        high_accuracy_out;
  logic [12:0] notch1_frequency_setting_out;
  logic [3:0]  notch1_shape_setting_out;
  logic        shaft_filter1_en_out;
  logic [12:0] shaft_filter_freq_out;
  logic        shaft_filter2_en_out;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  code_tab [0:13] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h1f, 8'h20, 8'h27,
                                   8'h28, 8'h29, 8'h2b, 8'h64, 8'h9f, 8'ha0, 8'hff};
  logic [12:0] hz_tab [0:13]   = '{13'h0, 13'h0, 13'h1194, 13'h0505, 13'h0122, 13'h0, 13'h0,
                                   13'h1194, 13'h0fa0, 13'h0cc8, 13'h0211, 13'h011b,
                                   13'h0, 13'h0};

  always #12.5 clk_sys_in = ~clk_sys_in;

  rftc_top #(.TUNE_LIMIT_CYC(LIM)) u_dut (
    .clk_sys_in                  (clk_sys_in),
    .reset_n_in                  (reset_n_in),
    .avs_address_in              (avs_address_in),
    .avs_read_in                 (avs_read_in),
    .avs_write_in                (avs_write_in),
    .avs_writedata_in            (avs_writedata_in),
    .avs_byteenable_in           (avs_byteenable_in),
    .avs_readdata_out            (avs_readdata_out),
    .avs_waitrequest_out         (avs_waitrequest_out),
    .quick_tuning_busy_in        (quick_tuning_busy_in),
    .resonance_valid_in          (resonance_valid_in),
    .resonance_freq_in           (resonance_freq_in),
    .resonance_depth_in          (resonance_depth_in),
    .motor_type_in               (motor_type_in),
    .inertia_ratio_in            (inertia_ratio_in),
    .tuning_busy_out             (tuning_busy_out),
    .excite_en_out               (excite_en_out),
    .excite_amp_out              (excite_amp_out),
    .high_accuracy_out           (high_accuracy_out),
    .notch1_frequency_setting_out(notch1_frequency_setting_out),
    .notch1_shape_setting_out    (notch1_shape_setting_out),
    .shaft_filter1_en_out        (shaft_filter1_en_out),
    .shaft_filter_freq_out       (shaft_filter_freq_out),
    .shaft_filter2_en_out        (shaft_filter2_en_out)
  );

  task automatic print_verdict();
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_pin(input string name, input logic [12:0] exp, input logic [12:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // an idle edge after release keeps back-to-back calls from driving a strobe twice at once
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= 1'b1;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    avs_address_in <= a;
    avs_read_in    <= 1'b1;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic read_check(input string name, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_read(a, d);
    check_word(name, exp, d);
  endtask

  task automatic status_check(input logic [7:0] code, input logic [12:0] hz);
    logic [31:0] d;
    bus_read(OFS_STATUS, d);
    check_word("status code", {24'h0, code}, {24'h0, d[15:8]});
    check_pin("status hz", hz, d[28:16]);
  endtask

  initial begin
    tick(2);
    reset_n_in <= 1'b1;
    tick(1);
    read_check("ctrl reset", OFS_CTRL, 32'h0000_0100);
    read_check("code reset", OFS_CODE, 32'h0);
    read_check("notch1 reset", OFS_NOTCH1, 32'h0);
    check_pin("amp reset", 13'h1, {11'h0, excite_amp_out});
    check_pin("busy idle", 13'h0, {12'h0, tuning_busy_out});
    read_check("unmapped read", 4'h2, 32'h0);
    bus_write(4'h2, 32'hffff_ffff);
    read_check("ctrl after unmapped", OFS_CTRL, 32'h0000_0100);
    // manual shaft code walks the frequency table, disabled codes included
    bus_write(OFS_CTRL, 32'h0000_0110);
    for (int i = 0; i < 14; i++) begin
      bus_write(OFS_CODE, {24'h0, code_tab[i]});
      tick(40);
      check_pin("shaft hz", hz_tab[i], shaft_filter_freq_out);
      check_pin("shaft en", {12'h0, hz_tab[i] != 13'h0}, {12'h0, shaft_filter1_en_out});
      status_check(code_tab[i], hz_tab[i]);
    end
    // automatic code from motor type and inertia, then saturated at the top code
    motor_type_in    <= 4'h2;
    inertia_ratio_in <= 8'h08;
    bus_write(OFS_CTRL, 32'h0000_0100);
    tick(40);
    status_check(8'h32, 13'h07d0);
    motor_type_in    <= 4'hf;
    inertia_ratio_in <= 8'hff;
    tick(40);
    status_check(8'h9f, 13'h011b);
    bus_write(OFS_CTRL, 32'h0000_0120);
    tick(40);
    check_pin("shaft off", 13'h0, {12'h0, shaft_filter1_en_out});
    // notch 4 locks shaft filter 1 and its settings
    bus_write(OFS_CTRL, 32'h0000_0110);
    bus_write(OFS_CODE, 32'h0000_0028);
    bus_write(OFS_CTRL, 32'h0000_2110);
    tick(40);
    check_pin("shaft1 n4", 13'h0, {12'h0, shaft_filter1_en_out});
    bus_write(OFS_CODE, 32'h0000_0002);
    bus_write(OFS_CTRL, 32'h0000_2120);
    read_check("code locked", OFS_CODE, 32'h0000_0028);
    read_check("ssel locked", OFS_CTRL, 32'h0000_2110);
    bus_write(OFS_CTRL, 32'h0000_0110);
    tick(40);
    check_pin("shaft1 back", 13'h1, {12'h0, shaft_filter1_en_out});
    // notch 3 locks the second shaft filter
    bus_write(OFS_CTRL, 32'h0000_1110);
    tick(4);
    check_pin("shaft2 n3", 13'h0, {12'h0, shaft_filter2_en_out});
    bus_write(OFS_CTRL, 32'h0000_1010);
    read_check("s2sel locked", OFS_CTRL, 32'h0000_1110);
    bus_write(OFS_CTRL, 32'h0000_0110);
    bus_write(OFS_CTRL, 32'h0000_0010);
    tick(4);
    check_pin("shaft2 dis", 13'h0, {12'h0, shaft_filter2_en_out});
    bus_write(OFS_CTRL, 32'h0000_0110);
    tick(4);
    check_pin("shaft2 auto", 13'h1, {12'h0, shaft_filter2_en_out});
    // tuning refused while quick tuning runs, then detection with excitation
    quick_tuning_busy_in <= 1'b1;
    bus_write(OFS_CTRL, 32'h0000_0101);
    tick(5);
    check_pin("quick block", 13'h0, {12'h0, tuning_busy_out});
    quick_tuning_busy_in <= 1'b0;
    tick(4);
    check_pin("detecting", 13'h1, {12'h0, tuning_busy_out});
    check_pin("excite on", 13'h1, {12'h0, excite_en_out});
    check_pin("amp std", 13'h1, {11'h0, excite_amp_out});
    resonance_freq_in  <= 13'h0032;
    resonance_depth_in <= 4'h5;
    resonance_valid_in <= 1'b1;
    tick(1);
    resonance_valid_in <= 1'b0;
    tick(3);
    check_pin("out of band", 13'h1, {12'h0, tuning_busy_out});
    resonance_freq_in  <= 13'h03e8;
    resonance_valid_in <= 1'b1;
    tick(1);
    resonance_valid_in <= 1'b0;
    tick(3);
    check_pin("tuned idle", 13'h0, {12'h0, tuning_busy_out});
    check_pin("excite off", 13'h0, {12'h0, excite_en_out});
    check_pin("notch1 hz", 13'h03e8, notch1_frequency_setting_out);
    check_pin("notch1 depth", 13'h5, {9'h0, notch1_shape_setting_out});
    read_check("mode manual", OFS_CTRL, 32'h0000_0102);
    read_check("notch1 reg", OFS_NOTCH1, 32'h0005_03e8);
    // high accuracy run with no resonance ends at the detection limit
    bus_write(OFS_CTRL, 32'h0000_0109);
    tick(4);
    check_pin("hi acc", 13'h1, {12'h0, high_accuracy_out});
    check_pin("amp hi", 13'h3, {11'h0, excite_amp_out});
    tick(150);
    check_pin("still busy", 13'h1, {12'h0, tuning_busy_out});
    tick(LIM - 140);
    check_pin("timed out", 13'h0, {12'h0, tuning_busy_out});
    check_pin("notch1 zero", 13'h0, notch1_frequency_setting_out);
    read_check("mode after limit", OFS_CTRL, 32'h0000_010a);
    // manual mode: software owns notch 1, reserved mode code is dropped
    bus_write(OFS_NOTCH1, 32'h0003_0190);
    tick(2);
    check_pin("manual notch", 13'h0190, notch1_frequency_setting_out);
    check_pin("manual idle", 13'h0, {12'h0, tuning_busy_out});
    bus_write(OFS_CTRL, 32'h0000_010b);
    read_check("mode 3 dropped", OFS_CTRL, 32'h0000_010a);
    bus_write(OFS_CTRL, 32'h0000_0100);
    tick(4);
    check_pin("disabled idle", 13'h0, {12'h0, tuning_busy_out});
    print_verdict();
  end
endmodule // resonance_filter_tuning_ctrl_test
